// ### common/sdis_consts.svh
// Offsets, field positions, reset values and masks of the interrupt status block
`ifndef SDIS_CONSTS_SVH
`define SDIS_CONSTS_SVH
`define SDIS_OFF_STATUS      12'h030
`define SDIS_OFF_STAT_EN     12'h034
`define SDIS_OFF_SIG_EN      12'h038
`define SDIS_OFF_AC12_ERR    12'h03C
`define SDIS_OFF_CTRL        12'h040
`define SDIS_BIT_CARD        8
`define SDIS_BIT_ERRSUM      15
`define SDIS_BIT_CUR_LIMIT   23
`define SDIS_BIT_AC12        24
`define SDIS_BIT_TGT_RESP    28
`define SDIS_VEND_LSB        29
`define SDIS_NORM_MASK       16'h7FFF
`define SDIS_ERR_MASK        16'hF1FF
`define SDIS_EN_RESET        32'h0000_0000
`define SDIS_AC12_WIDTH      8
`define SDIS_RESP_OKAY       2'h0
`define SDIS_RESP_SLVERR     2'h2
`endif

// ### common/sdis_pkg.sv
// Types shared by the interrupt status block
package sdis_pkg;
   typedef enum logic [1:0] {
      SDIS_IDLE  = 2'h0,
      SDIS_WRESP = 2'h1,
      SDIS_RRESP = 2'h3
   } sdis_bus_st_t;
endpackage

// ### hw/sdis_sync.sv
// Two-flop synchroniser for a vector of external levels
`timescale 1ns/1ps
module sdis_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sdis_sync_st_t;
   sdis_sync_st_t r_q, r_d;
   always_comb begin
      r_d    = r_q;
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end
   assign q = r_q.s2;
endmodule

// ### hw/sdis_rise.sv
// Rising-edge detector over a vector, pulses when any bit goes 0 to 1
`timescale 1ns/1ps
module sdis_rise #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic              any_rise
);
   typedef struct packed {
      logic [W-1:0] prev;
   } sdis_rise_st_t;
   sdis_rise_st_t r_q, r_d;
   always_comb begin
      r_d      = r_q;
      r_d.prev = d;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end
   assign any_rise = |(d & ~r_q.prev);
endmodule

// ### hw/sdis_top.sv
// SD host interrupt status, enables and request line behind AXI4-Lite
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sdis_consts.svh"
module sdis_top #(
   parameter bit HAS_CUR_LIMIT = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [14:0] norm_evt,
   input  wire logic        card_irq,
   input  wire logic [2:0]  vend_err_evt,
   input  wire logic        mst_err_resp,
   input  wire logic [7:0]  ac12_err,
   input  wire logic        ac12_skipped,
   input  wire logic        supply_cut,
   output logic             irq
);
   typedef struct packed {
      sdis_pkg::sdis_bus_st_t wst;
      sdis_pkg::sdis_bus_st_t rst;
      logic                   aw_got;
      logic                   w_got;
      logic [11:0]            awaddr;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic [1:0]             bresp;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      logic [15:0]            norm;
      logic [15:0]            err;
      logic [31:0]            stat_en;
      logic [31:0]            sig_en;
      logic                   irq;
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic                   arready;
      logic                   rvalid;
   } sdis_st_t;

   sdis_st_t r_q, r_d;
   logic [14:0] norm_s;
   logic        card_s;
   logic [2:0]  vend_s;
   logic        mst_s;
   logic        skip_s;
   logic        cut_s;
   logic [7:0]  ac12_s;
   logic        ac12_rise;
   logic        skip_rise;
   logic        mst_rise;
   logic        wr_fire;
   logic [31:0] wmask;
   logic [31:0] clr;
   logic [31:0] stat_raw;
   logic [31:0] stat_vis;
   logic        irq_norm;
   logic        irq_err;

   // Every pin-level event is synchronised before use
   sdis_sync #(.W(15)) u_sync_norm (
      .clk    (clk),
      .resetn (resetn),
      .d      (norm_evt),
      .q      (norm_s)
   );

   sdis_sync #(.W(1)) u_sync_card (
      .clk    (clk),
      .resetn (resetn),
      .d      (card_irq),
      .q      (card_s)
   );

   sdis_sync #(.W(3)) u_sync_vend (
      .clk    (clk),
      .resetn (resetn),
      .d      (vend_err_evt),
      .q      (vend_s)
   );

   sdis_sync #(.W(1)) u_sync_mst (
      .clk    (clk),
      .resetn (resetn),
      .d      (mst_err_resp),
      .q      (mst_s)
   );

   sdis_sync #(.W(1)) u_sync_skip (
      .clk    (clk),
      .resetn (resetn),
      .d      (ac12_skipped),
      .q      (skip_s)
   );

   sdis_sync #(.W(1)) u_sync_cut (
      .clk    (clk),
      .resetn (resetn),
      .d      (supply_cut),
      .q      (cut_s)
   );

   sdis_sync #(.W(8)) u_sync_ac12 (
      .clk    (clk),
      .resetn (resetn),
      .d      (ac12_err),
      .q      (ac12_s)
   );

   sdis_rise #(.W(8)) u_ac12 (
      .clk      (clk),
      .resetn   (resetn),
      .d        (ac12_s),
      .any_rise (ac12_rise)
   );

   // The skip and master-error levels become single events so a held level cannot re-set a
   // flag that software has just cleared
   sdis_rise #(.W(1)) u_skip (
      .clk      (clk),
      .resetn   (resetn),
      .d        (skip_s),
      .any_rise (skip_rise)
   );

   sdis_rise #(.W(1)) u_mst (
      .clk      (clk),
      .resetn   (resetn),
      .d        (mst_s),
      .any_rise (mst_rise)
   );

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{s[i]}};
      end
      return m;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a[11:2] == o[11:2];
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return hit(a, `SDIS_OFF_STATUS) || hit(a, `SDIS_OFF_STAT_EN)
          || hit(a, `SDIS_OFF_SIG_EN) || hit(a, `SDIS_OFF_AC12_ERR)
          || hit(a, `SDIS_OFF_CTRL);
   endfunction

   // Byte lanes outside the strobe keep their old value
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      return (old_v & ~m) | (new_v & m);
   endfunction

   // One word per register; unmapped words read as zero
   function automatic logic [31:0] read_mux(input logic [11:0] a,
                                            input logic [31:0] status,
                                            input logic [31:0] st_en,
                                            input logic [31:0] sg_en,
                                            input logic [7:0]  ac12);
      logic [31:0] v;
      v = '0;
      if (hit(a, `SDIS_OFF_STATUS)) begin
         v = status;
      end
      if (hit(a, `SDIS_OFF_STAT_EN)) begin
         v = st_en;
      end
      if (hit(a, `SDIS_OFF_SIG_EN)) begin
         v = sg_en;
      end
      if (hit(a, `SDIS_OFF_AC12_ERR)) begin
         v = {24'h000000, ac12};
      end
      if (hit(a, `SDIS_OFF_CTRL)) begin
         v = {31'h00000000, HAS_CUR_LIMIT};
      end
      return v;
   endfunction

   always_comb begin
      wr_fire = r_q.aw_got && r_q.w_got && (r_q.wst == sdis_pkg::SDIS_IDLE);
      wmask   = strb_mask(r_q.wstrb);
      clr     = '0;
      if (wr_fire && hit(r_q.awaddr, `SDIS_OFF_STATUS)) begin
         clr = r_q.wdata & wmask;
      end
      stat_raw        = {r_q.err, r_q.norm};
      stat_raw[`SDIS_BIT_CUR_LIMIT] = HAS_CUR_LIMIT && cut_s;
      stat_raw[`SDIS_BIT_CARD]      = card_s;
      stat_raw[`SDIS_BIT_ERRSUM]    = |(stat_raw[31:16] & r_q.stat_en[31:16]);
      stat_vis = stat_raw & r_q.stat_en;
      irq_norm = |(stat_vis[15:0] & r_q.sig_en[15:0]);
      irq_err  = |(stat_vis[31:16] & r_q.sig_en[31:16]);
   end

   always_comb begin
      r_d = r_q;
      // Normal flags: hardware set beats a write-one clear
      for (int i = 0; i < 15; i++) begin
         if (norm_s[i]) begin
            r_d.norm[i] = 1'b1;
         end else if (clr[i]) begin
            r_d.norm[i] = 1'b0;
         end
      end
      r_d.norm[`SDIS_BIT_CARD]   = 1'b0;
      r_d.norm[`SDIS_BIT_ERRSUM] = 1'b0;
      // Error flags
      r_d.err = (r_q.err & ~clr[31:16]) & `SDIS_ERR_MASK;
      r_d.err[`SDIS_BIT_CUR_LIMIT - 16] = 1'b0;
      for (int v = 0; v < 3; v++) begin
         if (vend_s[v]) begin
            r_d.err[`SDIS_VEND_LSB - 16 + v] = 1'b1;
         end
      end
      if (mst_rise) begin
         r_d.err[`SDIS_BIT_TGT_RESP - 16] = 1'b1;
      end
      if (ac12_rise || skip_rise) begin
         r_d.err[`SDIS_BIT_AC12 - 16] = 1'b1;
      end
      // Write channel
      if (s_axi_awvalid && !r_q.aw_got) begin
         r_d.aw_got = 1'b1;
         r_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r_q.w_got) begin
         r_d.w_got = 1'b1;
         r_d.wdata = s_axi_wdata;
         r_d.wstrb = s_axi_wstrb;
      end
      unique case (r_q.wst)
         sdis_pkg::SDIS_IDLE: begin
            if (wr_fire) begin
               r_d.wst   = sdis_pkg::SDIS_WRESP;
               r_d.bresp = mapped(r_q.awaddr) ? `SDIS_RESP_OKAY
                                              : `SDIS_RESP_SLVERR;
               if (hit(r_q.awaddr, `SDIS_OFF_STAT_EN)) begin
                  r_d.stat_en = merge(r_q.stat_en, r_q.wdata, wmask);
               end
               if (hit(r_q.awaddr, `SDIS_OFF_SIG_EN)) begin
                  r_d.sig_en = merge(r_q.sig_en, r_q.wdata, wmask);
               end
            end
         end
         sdis_pkg::SDIS_WRESP: begin
            if (s_axi_bready) begin
               r_d.wst    = sdis_pkg::SDIS_IDLE;
               r_d.aw_got = 1'b0;
               r_d.w_got  = 1'b0;
            end
         end
         default: r_d.wst = sdis_pkg::SDIS_IDLE;
      endcase
      // Read channel
      unique case (r_q.rst)
         sdis_pkg::SDIS_IDLE: begin
            if (s_axi_arvalid) begin
               r_d.rst   = sdis_pkg::SDIS_RRESP;
               r_d.rresp = mapped(s_axi_araddr) ? `SDIS_RESP_OKAY
                                                : `SDIS_RESP_SLVERR;
               r_d.rdata = read_mux(s_axi_araddr, stat_vis, r_q.stat_en,
                                    r_q.sig_en, ac12_s);
            end
         end
         sdis_pkg::SDIS_RRESP: begin
            if (s_axi_rready) begin
               r_d.rst = sdis_pkg::SDIS_IDLE;
            end
         end
         default: r_d.rst = sdis_pkg::SDIS_IDLE;
      endcase
      // Request follows visible-and-signalled flags one cycle later
      r_d.irq = irq_norm || irq_err;
      // Handshake outputs are registered copies of the next state
      r_d.awready = !r_d.aw_got;
      r_d.wready  = !r_d.w_got;
      r_d.bvalid  = r_d.wst == sdis_pkg::SDIS_WRESP;
      r_d.arready = r_d.rst == sdis_pkg::SDIS_IDLE;
      r_d.rvalid  = r_d.rst == sdis_pkg::SDIS_RRESP;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_q         <= '0;
         r_q.wst     <= sdis_pkg::SDIS_IDLE;
         r_q.rst     <= sdis_pkg::SDIS_IDLE;
         r_q.stat_en <= `SDIS_EN_RESET;
         r_q.sig_en  <= `SDIS_EN_RESET;
         r_q.awready <= 1'b1;
         r_q.wready  <= 1'b1;
         r_q.arready <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign s_axi_awready = r_q.awready;
   assign s_axi_wready  = r_q.wready;
   assign s_axi_bvalid  = r_q.bvalid;
   assign s_axi_bresp   = r_q.bresp;
   assign s_axi_arready = r_q.arready;
   assign s_axi_rvalid  = r_q.rvalid;
   assign s_axi_rdata   = r_q.rdata;
   assign s_axi_rresp   = r_q.rresp;
   assign irq           = r_q.irq;
endmodule

// ### verif/sdis_src.sv
// Event source model: the controller logic that feeds the status block
`timescale 1ns/1ps
module sdis_src (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [2:0]  ev,
   input  wire logic [14:0] val,
   output logic [14:0]      norm_evt,
   output logic             card_irq,
   output logic [2:0]       vend_err_evt,
   output logic             mst_err_resp,
   output logic [7:0]       ac12_err,
   output logic             ac12_skipped,
   output logic             supply_cut
);
   logic [1:0] cnt_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {norm_evt, card_irq, vend_err_evt, ac12_err, supply_cut} <= '0;
         {mst_err_resp, ac12_skipped, cnt_q} <= '0;
      end else begin
         case (ev)
            3'h1: vend_err_evt <= val[2:0];
            3'h3: ac12_err <= val[7:0];
            3'h5: supply_cut <= val[0];
            3'h6: card_irq <= val[0]; // Held until serviced
            3'h7: norm_evt <= val;
            default: ;
         endcase
         // Pulses last 4 cycles so the two-flop sync cannot miss them
         if (ev == 3'h2 || ev == 3'h4) begin
            mst_err_resp <= (ev == 3'h2);
            ac12_skipped <= (ev == 3'h4);
            cnt_q <= 2'h3;
         end else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
         else {mst_err_resp, ac12_skipped} <= 2'h0;
      end
   end
endmodule

// ### verif/sdis_top_chk.sv
// Handshake and request line checks on the status block ports
`timescale 1ns/1ps
`include "sdis_consts.svh"
module sdis_top_chk (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_b_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_r_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while answer pending");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_unmap_zero: assert property (
      s_axi_rvalid && s_axi_rresp == `SDIS_RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   a_b_once: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
      else $error("write answer withdrawn");
   a_irq_quiet: assert property ($rose(resetn) |-> !irq [*3])
      else $error("request raised with enables off");
endmodule
bind sdis_top sdis_top_chk u_chk (.*);

// ### verif/test_sdis_top.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/1ps
`include "sdis_consts.svh"
module test_sdis_top;
   localparam logic [11:0] ST = `SDIS_OFF_STATUS;
   localparam logic [11:0] SE = `SDIS_OFF_STAT_EN;
   localparam logic [11:0] SG = `SDIS_OFF_SIG_EN;
   localparam logic [11:0] NM = 12'h0FC;
   localparam logic [31:0] E28 = 32'h1 << `SDIS_BIT_TGT_RESP;
   localparam logic [31:0] E24 = 32'h1 << `SDIS_BIT_AC12;
   localparam logic [31:0] E23 = 32'h1 << `SDIS_BIT_CUR_LIMIT;
   localparam logic [31:0] ES = 32'h1 << `SDIS_BIT_ERRSUM;
   localparam logic [31:0] CD = 32'h1 << `SDIS_BIT_CARD;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic        clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, card_irq;
   logic        mst_err_resp, ac12_skipped, supply_cut;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, ve, nv, exp_q[$];
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$], rsp_q[$];
   logic [14:0] norm_evt, val;
   logic [7:0]  ac12_err, a;
   logic [2:0]  vend_err_evt, ev;
   int          failures, checks_done, seed;
   sdis_top u_dut (.*);
   sdis_src u_src (.*);
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task ci(input logic e);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   task wr(input logic [11:0] ad, input logic [31:0] d);
      bq.push_back(`SDIS_RESP_OKAY);
      @(posedge clk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge clk) begin
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [11:0] ad, input logic [31:0] e);
      exp_q.push_back(e);
      rsp_q.push_back(ad == NM ? `SDIS_RESP_SLVERR : `SDIS_RESP_OKAY);
      @(posedge clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk) if (s_axi_arready) s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   // Events need the sync delay before they show in the status
   task evt(input logic [2:0] c, input logic [14:0] d);
      @(posedge clk);
      ev <= c;
      val <= d;
      @(posedge clk);
      ev <= 3'h0;
      repeat (6) @(posedge clk);
   endtask
   task test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         chk("rdata", exp_q.pop_front(), s_axi_rdata);
         chk("rresp", 32'(rsp_q.pop_front()), 32'(s_axi_rresp));
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         chk("bresp", 32'(bq.pop_front()), 32'(s_axi_bresp));
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      test_done();
   end
   initial begin
      seed = 21035;
      resetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, ev, val} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(ST, 32'h0);
      rd(SE, 32'h0);
      rd(NM, 32'h0);
      ci(1'b0);
      $display("test reset end");
      ve = {3'($random(seed)) | 3'h1, 29'h0};
      a = 8'h1 << 3'($random(seed));
      wr(SE, ALL);
      evt(3'h1, 15'(ve[31:29]));
      evt(3'h2, 15'h0);
      evt(3'h5, 15'h1);
      evt(3'h3, 15'(a));
      rd(ST, ve | E28 | E24 | E23 | ES);
      rd(`SDIS_OFF_AC12_ERR, 32'(a));
      ci(1'b0);
      wr(SG, ALL);
      repeat (3) @(posedge clk);
      ci(1'b1);
      wr(ST, E28 | E24 | E23);
      rd(ST, ve | E23 | ES);
      evt(3'h4, 15'h0);
      rd(ST, ve | E24 | E23 | ES);
      wr(ST, ve);
      rd(ST, ve | E24 | E23 | ES);
      evt(3'h1, 15'h0);
      wr(ST, 32'hE100_0000);
      rd(ST, E23 | ES);
      evt(3'h5, 15'h0);
      rd(ST, 32'h0);
      ci(1'b0);
      $display("test error end");
      evt(3'h2, 15'h0);
      wr(SE, 32'h0);
      rd(ST, 32'h0);
      ci(1'b0);
      wr(SE, ALL);
      rd(ST, E28 | ES);
      wr(ST, E28);
      nv = 32'($random(seed)) & 32'h0000_7EFF;
      evt(3'h7, nv[14:0]);
      evt(3'h6, 15'h1);
      evt(3'h7, 15'h0);
      rd(ST, nv | CD);
      ci(1'b1);
      wr(ST, 32'h0000_FFFF);
      rd(ST, CD);
      evt(3'h6, 15'h0);
      rd(ST, 32'h0);
      ci(1'b0);
      $display("test normal end");
      test_done();
   end
endmodule
